// ===== include/stns_pkg.sv
// constants and types for the target negotiation and status block
// Summary of operation
// - reply offset not larger, period not shorter
// - device proposes safe offset and workable period
// - zero offset or reject means asynchronous
// - agreement holds until reset or renegotiation
// - asynchronous mode after power, device reset, RST
// - negotiate only after selection with both IDs
// - good status code 0H on success
// - check condition 2H when sense set
// - busy 8H when command cannot be accepted
// - intermediate 10H in chain, else chain breaks
// - reservation conflict 18H for other owners
// - check condition holds allegiance until cleared
// - sense data returned clears the allegiance
// - other initiators get busy during allegiance
// - wait 2.4 us before arbitration check
// - wait 200 us after disconnect before arbitration
// - request negated at least 90 ns; code enforces this in synchronous mode only
// - ready within 250 us reset, 10 s power
// - no busy answer 18 us after select
// - wait 250 us for busy before timeout
// - period field counts 4 ns units
// - offset at most 15, zero is asynchronous
`default_nettype none
package stns_pkg;
  localparam int CLK_NS = 4;
  localparam int PER_UNIT_NS = 4;
  localparam int ARB_NS = 2400;
  localparam int ARB_CYC = (ARB_NS + CLK_NS - 1) / CLK_NS;
  localparam int NEG_NS = 90;
  localparam int NEG_CYC = (NEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ASRT_NS = 30;
  localparam int ASRT_CYC = (ASRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int DISC_US = 200;
  localparam int SELAB_US = 18;
  localparam int SELTO_US = 250;
  localparam int RSTRDY_US = 250;
  localparam longint PWRRDY_S = 10;
  localparam int unsigned DISC_CYC = (DISC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SELAB_CYC = SELAB_US * 1000 / CLK_NS;
  localparam int unsigned SELTO_CYC = (SELTO_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RSTRDY_CYC = RSTRDY_US * 1000 / CLK_NS;
  localparam int unsigned PWRRDY_CYC = 32'(PWRRDY_S * 1000000000 / CLK_NS);
  localparam logic [7:0] NEG_LIM = 8'(NEG_CYC - 1);
  localparam logic [7:0] ASRT_LIM = 8'(ASRT_CYC - 1);
  localparam logic [7:0] SAT8 = 8'hFF;
  localparam int TMR_W = 32;
  localparam int N_TMR = 5;
  localparam int T_ARB = 0;
  localparam int T_DISC = 1;
  localparam int T_SELAB = 2;
  localparam int T_SELTO = 3;
  localparam int T_READY = 4;
  localparam logic [7:0] MAX_OFFSET = 8'h0F;
  localparam logic [7:0] DEV_OFFSET = 8'h08;
  localparam logic [7:0] DEV_PERIOD = 8'h19;
  localparam logic [7:0] MIN_PERIOD = 8'h19;
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_BUSY = 8'h08;
  localparam logic [7:0] ST_INTER = 8'h10;
  localparam logic [7:0] ST_CONFLICT = 8'h18;
  typedef enum logic [1:0] {
    NEG_IDLE = 2'b00,
    NEG_WAIT = 2'b01
  } stns_neg_type;
  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_HIGH = 2'b01,
    REQ_LOW  = 2'b10
  } stns_req_type;
  typedef struct packed {
    logic [7:0] period;
    logic [7:0] offset;
  } stns_sdtr_type;
  typedef struct packed {
    logic       valid;
    logic [2:0] init_id;
    logic       is_sense;
  } stns_start_type;
  typedef struct packed {
    logic       valid;
    logic [2:0] init_id;
    logic       check;
    logic       no_accept;
    logic       reserved_other;
    logic       linked;
    logic       last;
  } stns_end_type;
endpackage
`default_nettype wire

// ===== core/stns_timer.sv
// one-shot delay timer, restarted by every start pulse
`default_nettype none
module stns_timer
  import stns_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [TMR_W-1:0] target,
  output logic                  expired
);
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             run_r;

  assign cnt_nxt = cnt_r + 32'h1;

  // expired rises exactly target edges after the start edge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      run_r <= 1'b1;
      expired <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_nxt;
      if (cnt_nxt >= target) begin
        run_r <= 1'b0;
        expired <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/stns_core.sv
// target negotiation, completion status, allegiance and bus timing
`default_nettype none
module stns_core
  import stns_pkg::*;
#(
  parameter int unsigned DISC_CYCLES   = DISC_CYC,
  parameter int unsigned SELAB_CYCLES  = SELAB_CYC,
  parameter int unsigned SELTO_CYCLES  = SELTO_CYC,
  parameter int unsigned RSTRDY_CYCLES = RSTRDY_CYC,
  parameter int unsigned PWRRDY_CYCLES = PWRRDY_CYC
)
(
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  input  wire logic           bus_rst,
  input  wire logic           nexus_ok,
  input  wire logic           neg_start,
  input  wire logic           sdtr_rx_valid,
  input  wire stns_sdtr_type  sdtr_rx,
  input  wire logic           msg_reject_rx,
  input  wire logic           bdr_rx,
  input  wire logic           abort_rx,
  input  wire stns_start_type cmd_start,
  input  wire stns_end_type   cmd_end,
  input  wire logic           sense_done,
  input  wire logic [2:0]     sense_id,
  input  wire logic           arb_begin,
  input  wire logic           disc_release,
  input  wire logic           sel_seen,
  input  wire logic           resel_begin,
  input  wire logic           bsy_seen,
  input  wire logic           xfer_want,
  input  wire logic           ack_in,
  output logic                sdtr_tx_valid,
  output stns_sdtr_type       sdtr_tx,
  output stns_sdtr_type       agreed,
  output logic                sync_mode,
  output logic                status_valid,
  output logic [7:0]          status_byte,
  output logic                link_broken,
  output logic                ca_active,
  output logic [2:0]          ca_owner,
  output logic                arb_check_ok,
  output logic                arb_allowed,
  output logic                bsy_resp_ok,
  output logic                sel_timeout,
  output logic                unit_ready,
  output logic                req_out,
  output logic [4:0]          req_pending
);
  stns_neg_type    neg_state_r;
  stns_req_type    req_st_r;
  stns_sdtr_type   agreed_r;
  stns_sdtr_type   tx_r;
  stns_sdtr_type   reply;
  logic            tx_valid_r;
  logic            sync_mode_r;
  logic            status_valid_r;
  logic [7:0]      status_byte_r;
  logic [7:0]      end_code;
  logic            link_broken_r;
  logic            ca_active_r;
  logic [2:0]      ca_owner_r;
  logic            ca_other;
  logic            ca_set;
  logic            ca_clr;
  logic            arb_allowed_r;
  logic            bsy_ok_r;
  logic            selto_wait_r;
  logic            sel_to_r;
  logic            ready_r;
  logic            boot_r;
  logic            pwr_phase_r;
  logic            req_r;
  logic            req_go;
  logic            ack_q_r;
  logic            ack_rise;
  logic [4:0]      outst_r;
  logic [7:0]      gap_r;
  logic [7:0]      lo_r;
  logic [7:0]      hi_r;
  logic [7:0]      per_cyc;
  logic [N_TMR-1:0] tmr_start;
  logic [N_TMR-1:0] tmr_exp;
  logic [TMR_W-1:0] tmr_target [N_TMR];

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a,
                                      input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  // busy outranks everything: an unaccepted command was never run
  function automatic logic [7:0] status_code(input stns_end_type e,
                                             input logic blocked);
    if (e.no_accept || blocked) begin
      status_code = ST_BUSY;
    end else if (e.reserved_other) begin
      status_code = ST_CONFLICT;
    end else if (e.check) begin
      status_code = ST_CHECK;
    end else if (e.linked && !e.last) begin
      status_code = ST_INTER;
    end else begin
      status_code = ST_GOOD;
    end
  endfunction

  // ---- negotiation ----
  // reply clamps to our limits: offset down, period up
  assign reply.offset = min8(sdtr_rx.offset, MAX_OFFSET);
  assign reply.period = max8(sdtr_rx.period, MIN_PERIOD);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      neg_state_r <= NEG_IDLE;
      agreed_r <= '0;
      tx_r <= '0;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= 1'b0;
      if (bus_rst || bdr_rx) begin
        neg_state_r <= NEG_IDLE;
        agreed_r <= '0;
      end else begin
        case (neg_state_r)
          NEG_IDLE: begin
            if (sdtr_rx_valid && nexus_ok) begin
              tx_valid_r <= 1'b1;
              tx_r <= reply;
              agreed_r <= reply;
            end else if (neg_start && nexus_ok) begin
              tx_valid_r <= 1'b1;
              tx_r.offset <= DEV_OFFSET;
              tx_r.period <= DEV_PERIOD;
              neg_state_r <= NEG_WAIT;
            end
          end
          NEG_WAIT: begin
            if (msg_reject_rx) begin
              agreed_r <= '0;
              neg_state_r <= NEG_IDLE;
            end else if (sdtr_rx_valid) begin
              // an answer outside our proposal is not trusted
              if (sdtr_rx.offset != 8'h00 &&
                  sdtr_rx.offset <= DEV_OFFSET &&
                  sdtr_rx.period >= DEV_PERIOD) begin
                agreed_r <= sdtr_rx;
              end else begin
                agreed_r <= '0;
              end
              neg_state_r <= NEG_IDLE;
            end
          end
          default: neg_state_r <= NEG_IDLE;
        endcase
      end
    end
  end

  // follows the agreement one cycle later
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync_mode_r <= 1'b0;
    end else begin
      sync_mode_r <= (agreed_r.offset != 8'h00);
    end
  end

  // ---- completion status ----
  assign ca_other = ca_active_r && (cmd_end.init_id != ca_owner_r);
  assign end_code = status_code(cmd_end, ca_other);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_valid_r <= 1'b0;
      status_byte_r <= ST_GOOD;
      link_broken_r <= 1'b0;
    end else begin
      status_valid_r <= cmd_end.valid;
      if (bus_rst || bdr_rx) begin
        link_broken_r <= 1'b0;
      end else if (cmd_end.valid) begin
        status_byte_r <= end_code;
        link_broken_r <= cmd_end.linked && !cmd_end.last &&
                         (end_code != ST_INTER);
      end
    end
  end

  // ---- contingent allegiance ----
  assign ca_set = cmd_end.valid && (end_code == ST_CHECK);
  assign ca_clr = bus_rst || abort_rx || bdr_rx ||
                  (cmd_start.valid && !cmd_start.is_sense &&
                   cmd_start.init_id == ca_owner_r) ||
                  (sense_done && sense_id == ca_owner_r);

  // a fresh check condition wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ca_active_r <= 1'b0;
      ca_owner_r <= 3'h0;
    end else if (ca_set) begin
      ca_active_r <= 1'b1;
      ca_owner_r <= cmd_end.init_id;
    end else if (ca_clr) begin
      ca_active_r <= 1'b0;
    end
  end

  // ---- bus timing ----
  assign tmr_start[T_ARB] = arb_begin;
  assign tmr_start[T_DISC] = disc_release;
  assign tmr_start[T_SELAB] = sel_seen;
  assign tmr_start[T_SELTO] = resel_begin;
  assign tmr_start[T_READY] = boot_r || bus_rst;
  assign tmr_target[T_ARB] = TMR_W'(ARB_CYC);
  assign tmr_target[T_DISC] = DISC_CYCLES;
  assign tmr_target[T_SELAB] = SELAB_CYCLES;
  assign tmr_target[T_SELTO] = SELTO_CYCLES;
  assign tmr_target[T_READY] = pwr_phase_r ? PWRRDY_CYCLES
                                           : RSTRDY_CYCLES;

  generate
    for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
      stns_timer u_tmr (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .start   (tmr_start[i]),
        .target  (tmr_target[i]),
        .expired (tmr_exp[i])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      arb_allowed_r <= 1'b1;
      bsy_ok_r <= 1'b0;
    end else begin
      if (disc_release) begin
        arb_allowed_r <= 1'b0;
      end else if (tmr_exp[T_DISC]) begin
        arb_allowed_r <= 1'b1;
      end
      // retriggered on every select seen; late answers are dropped
      if (sel_seen) begin
        bsy_ok_r <= 1'b1;
      end else if (tmr_exp[T_SELAB]) begin
        bsy_ok_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      selto_wait_r <= 1'b0;
      sel_to_r <= 1'b0;
    end else begin
      sel_to_r <= 1'b0;
      if (resel_begin) begin
        selto_wait_r <= 1'b1;
      end else if (bsy_seen) begin
        selto_wait_r <= 1'b0;
      end else if (selto_wait_r && tmr_exp[T_SELTO]) begin
        selto_wait_r <= 1'b0;
        sel_to_r <= 1'b1;
      end
    end
  end

  // readiness: long wait after power-up, short one after bus reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      boot_r <= 1'b1;
      pwr_phase_r <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      if (bus_rst) begin
        pwr_phase_r <= 1'b0;
        ready_r <= 1'b0;
      end else if (tmr_exp[T_READY] && !boot_r) begin
        ready_r <= 1'b1;
      end
    end
  end

  // ---- request pacing ----
  assign per_cyc = 8'(32'(agreed_r.period) * PER_UNIT_NS / CLK_NS);
  assign ack_rise = ack_in && !ack_q_r;
  assign req_go = (req_st_r == REQ_IDLE) && xfer_want && !bus_rst &&
                  (!sync_mode_r ||
                   (({3'b000, outst_r} < agreed_r.offset) &&
                    gap_r >= per_cyc &&
                    lo_r >= NEG_LIM));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_q_r <= 1'b0;
      gap_r <= SAT8;
      lo_r <= SAT8;
      hi_r <= 8'h00;
    end else begin
      ack_q_r <= ack_in;
      if (req_go) begin
        gap_r <= 8'h01;
      end else if (gap_r != SAT8) begin
        gap_r <= gap_r + 8'h01;
      end
      if (req_r) begin
        lo_r <= 8'h00;
      end else if (lo_r != SAT8) begin
        lo_r <= lo_r + 8'h01;
      end
      if (req_r) begin
        hi_r <= hi_r + 8'h01;
      end else begin
        hi_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      req_st_r <= REQ_IDLE;
      req_r <= 1'b0;
    end else if (bus_rst) begin
      req_st_r <= REQ_IDLE;
      req_r <= 1'b0;
    end else begin
      case (req_st_r)
        REQ_IDLE: begin
          if (req_go) begin
            req_r <= 1'b1;
            req_st_r <= REQ_HIGH;
          end
        end
        REQ_HIGH: begin
          if (sync_mode_r && hi_r >= ASRT_LIM) begin
            req_r <= 1'b0;
            req_st_r <= REQ_IDLE;
          end else if (!sync_mode_r && ack_in) begin
            req_r <= 1'b0;
            req_st_r <= REQ_LOW;
          end
        end
        REQ_LOW: begin
          if (!ack_in) begin
            req_st_r <= REQ_IDLE;
          end
        end
        default: req_st_r <= REQ_IDLE;
      endcase
    end
  end

  // outstanding count only meaningful in synchronous mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      outst_r <= 5'h00;
    end else if (bus_rst || !sync_mode_r) begin
      outst_r <= 5'h00;
    end else if (req_go && !(ack_rise && outst_r != 5'h00)) begin
      outst_r <= outst_r + 5'h01;
    end else if (!req_go && ack_rise && outst_r != 5'h00) begin
      outst_r <= outst_r - 5'h01;
    end
  end

  assign sdtr_tx_valid = tx_valid_r;
  assign sdtr_tx = tx_r;
  assign agreed = agreed_r;
  assign sync_mode = sync_mode_r;
  assign status_valid = status_valid_r;
  assign status_byte = status_byte_r;
  assign link_broken = link_broken_r;
  assign ca_active = ca_active_r;
  assign ca_owner = ca_owner_r;
  assign arb_check_ok = tmr_exp[T_ARB];
  assign arb_allowed = arb_allowed_r;
  assign bsy_resp_ok = bsy_ok_r;
  assign sel_timeout = sel_to_r;
  assign unit_ready = ready_r;
  assign req_out = req_r;
  assign req_pending = outst_r;

  // ---- checks ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_reply_bound: assert property (
    neg_state_r == NEG_IDLE && sdtr_rx_valid && nexus_ok &&
    !bus_rst && !bdr_rx |=> tx_valid_r &&
    tx_r.offset <= $past(sdtr_rx.offset) &&
    tx_r.period >= $past(sdtr_rx.period))
    else $error("reply exceeds initiator request");
  a_offset_cap: assert property (
    agreed_r.offset <= MAX_OFFSET)
    else $error("agreed offset above limit");
  a_reject_async: assert property (
    neg_state_r == NEG_WAIT && msg_reject_rx && !bus_rst && !bdr_rx
    |=> agreed_r.offset == 8'h00 ##1 !sync_mode_r)
    else $error("reject did not force asynchronous");
  a_reset_async: assert property (
    bus_rst |=> agreed_r.offset == 8'h00 ##1 !sync_mode_r)
    else $error("bus reset left synchronous mode");
  a_nexus_gate: assert property (
    tx_valid_r |-> $past(nexus_ok))
    else $error("negotiation without full selection");
  a_ca_busy: assert property (
    cmd_end.valid && ca_other |=> status_byte_r == ST_BUSY)
    else $error("other initiator not told busy");
  a_check_hold: assert property (
    status_valid && status_byte_r == ST_CHECK |-> ca_active_r)
    else $error("check sent without allegiance");
  a_neg_period: assert property (
    $rose(req_r) && sync_mode_r |-> $past(lo_r) >= NEG_LIM)
    else $error("request negated too briefly");
  a_offset_pace: assert property (
    $rose(req_r) && sync_mode_r |->
    {3'b000, $past(outst_r)} < agreed_r.offset)
    else $error("too many requests outstanding");
  a_arb_wait: assert property (
    $rose(arb_check_ok) |-> $past(arb_begin, ARB_CYC + 1))
    else $error("arbitration check too early");

  c_reply: cover property (tx_valid_r && neg_state_r == NEG_IDLE);
  c_check: cover property (status_valid && status_byte_r == ST_CHECK);
  c_sync_req: cover property ($rose(req_r) && sync_mode_r);
  c_timeout: cover property (sel_to_r);
endmodule
`default_nettype wire

// ===== verification/stns_init_model.sv
// initiator stand-in: answers proposals and acknowledges requests
`default_nettype none
module stns_init_model
  import stns_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          sdtr_tx_valid,
  input  wire logic          req_out,
  input  wire logic          start,
  input  wire logic          arm,
  input  wire logic          reject,
  input  wire stns_sdtr_type ans,
  output logic               sdtr_rx_valid,
  output stns_sdtr_type      sdtr_rx,
  output logic               msg_reject_rx,
  output logic               ack_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int   pend = 0;
  logic req_d = 1'b0;
  logic done = 1'b0;
  initial begin
    sdtr_rx_valid = 1'b0;
    sdtr_rx = '0;
    msg_reject_rx = 1'b0;
    ack_in = 1'b0;
  end
  // own request, or answer to a device proposal when armed
  always @(posedge ref_clk) begin
    if (start || (arm && sdtr_tx_valid)) begin
      repeat (2) @(posedge ref_clk);
      if (reject) msg_reject_rx <= 1'b1;
      else sdtr_rx_valid <= 1'b1;
      sdtr_rx <= ans;
      @(posedge ref_clk);
      sdtr_rx_valid <= 1'b0;
      msg_reject_rx <= 1'b0;
      // a released message bus must not keep looking valid
      sdtr_rx <= ~ans;
    end
  end
  always @(posedge ref_clk) begin
    req_d <= req_out;
    if (!reset_n) pend <= 0;
    else pend <= pend + int'(req_out && !req_d) - int'(done);
  end
  // one acknowledge per request; each 32-cycle turn ends before the next paced request, so offsets do not build up
  initial forever begin
    @(posedge ref_clk);
    if (pend > 0) begin
      ack_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      ack_in <= 1'b0;
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
      repeat (22) @(posedge ref_clk);
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_stns_core.sv
// self-checking bench for the negotiation and status block
`default_nettype none
module test_stns_core
  import stns_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DSC = 50, SLA = 40, STO = 60, RRD = 30, PRD = 20;
  localparam logic [9:0] K_NEG = 10'h001, K_BDR = 10'h002, K_ABT = 10'h004;
  localparam logic [9:0] K_ARB = 10'h008, K_DSC = 10'h010, K_SEL = 10'h020;
  localparam logic [9:0] K_RSL = 10'h040, K_BSY = 10'h080, K_SNS = 10'h100;
  logic           ref_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           bus_rst = 1'b0;
  logic           nexus_ok = 1'b1;
  logic           xfer_want = 1'b0;
  logic           p_arm = 1'b0;
  logic           p_rej = 1'b0;
  logic [9:0]     pls = '0;
  logic [2:0]     sense_id = '0;
  stns_sdtr_type  p_ans = '0;
  stns_start_type cmd_start = '0;
  stns_end_type   cmd_end = '0;
  logic           sdtr_rx_valid, msg_reject_rx, ack_in, sdtr_tx_valid;
  logic           sync_mode, status_valid, link_broken, ca_active, req_q;
  logic           arb_check_ok, arb_allowed, bsy_resp_ok, sel_timeout;
  logic           unit_ready, req_out;
  stns_sdtr_type  sdtr_rx, sdtr_tx, agreed;
  logic [7:0]     status_byte;
  logic [2:0]     ca_owner;
  logic [4:0]     req_pending;
  logic [15:0]    tx_q[$];
  logic [8:0]     st_q[$];
  logic [4:0]     fl[8] = '{5'h00, 5'h08, 5'h04, 5'h02, 5'h03, 5'h06,
                            5'h0B, 5'h12};
  logic [8:0]     ex[8] = '{9'h000, 9'h008, 9'h018, 9'h010, 9'h000,
                            9'h118, 9'h008, 9'h102};
  int errors = 0, total_checks = 0, cnt = 0, last = 0, rises = 0, lo = 0;
  int gmin = 999, lomin = 999, pmax = 0, tos = 0, t0;

  stns_core #(.DISC_CYCLES(DSC), .SELAB_CYCLES(SLA), .SELTO_CYCLES(STO),
    .RSTRDY_CYCLES(RRD), .PWRRDY_CYCLES(PRD)) dut_u (
    .ref_clk, .reset_n, .bus_rst, .nexus_ok, .neg_start(pls[0]),
    .sdtr_rx_valid, .sdtr_rx, .msg_reject_rx, .bdr_rx(pls[1]),
    .abort_rx(pls[2]), .cmd_start, .cmd_end, .sense_done(pls[8]),
    .sense_id, .arb_begin(pls[3]), .disc_release(pls[4]),
    .sel_seen(pls[5]), .resel_begin(pls[6]), .bsy_seen(pls[7]),
    .xfer_want, .ack_in, .sdtr_tx_valid, .sdtr_tx, .agreed, .sync_mode,
    .status_valid, .status_byte, .link_broken, .ca_active, .ca_owner,
    .arb_check_ok, .arb_allowed, .bsy_resp_ok, .sel_timeout,
    .unit_ready, .req_out, .req_pending);
  stns_init_model init_u (.ref_clk, .reset_n, .sdtr_tx_valid, .req_out,
    .start(pls[9]), .arm(p_arm), .reject(p_rej), .ans(p_ans),
    .sdtr_rx_valid, .sdtr_rx, .msg_reject_rx, .ack_in);

  always #2 ref_clk = ~ref_clk;

  task automatic chk(string what, logic [17:0] e, logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic at(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(logic [9:0] m, logic [2:0] id);
    @(posedge ref_clk);
    pls <= m;
    sense_id <= id;
    @(posedge ref_clk);
    pls <= '0;
  endtask
  task automatic fin(logic [2:0] id, logic [4:0] f, logic [8:0] e);
    st_q.push_back(e);
    @(posedge ref_clk);
    cmd_end <= {1'b1, id, f};
    @(posedge ref_clk);
    cmd_end <= '0;
  endtask
  task automatic go(logic [2:0] id, logic s);
    @(posedge ref_clk);
    cmd_start <= {1'b1, id, s};
    @(posedge ref_clk);
    cmd_start <= '0;
  endtask
  task automatic ini(stns_sdtr_type r);
    stns_sdtr_type e;
    e.period = (r.period < MIN_PERIOD) ? MIN_PERIOD : r.period;
    e.offset = (r.offset > MAX_OFFSET) ? MAX_OFFSET : r.offset;
    tx_q.push_back(e);
    p_ans <= r;
    pulse(10'h200, 3'h0);
    at(6);
    chk("agreed", e, agreed);
    chk("sync_mode", e.offset != 8'h00, sync_mode);
  endtask
  task automatic dev(logic rj, stns_sdtr_type a, stns_sdtr_type e);
    tx_q.push_back({DEV_PERIOD, DEV_OFFSET});
    p_arm <= 1'b1;
    p_rej <= rj;
    p_ans <= a;
    pulse(K_NEG, 3'h0);
    at(8);
    chk("agreed", e, agreed);
    @(posedge ref_clk);
    p_arm <= 1'b0;
    p_rej <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // results are compared in order of their notes
  always @(posedge ref_clk) begin
    #1;
    if (sdtr_tx_valid === 1'b1)
      chk("sdtr_tx", tx_q.pop_front(), sdtr_tx);
    if (status_valid === 1'b1)
      chk("status", st_q.pop_front(), {link_broken, status_byte});
  end
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    req_q <= req_out;
    tos <= tos + int'(sel_timeout === 1'b1);
    lo <= (req_out === 1'b1) ? 0 : lo + 1;
    if (req_pending > pmax) pmax <= int'(req_pending);
    if (req_out === 1'b1 && req_q === 1'b0) begin
      rises <= rises + 1;
      last <= cnt;
      if (rises > 0 && cnt - last < gmin) gmin <= cnt - last;
      if (rises > 0 && lo < lomin) lomin <= lo;
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    void'($urandom(32'h20CF4C90));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    at(1);
    chk("agreed", 16'h0000, agreed);
    chk("ready", 2'b10, {arb_allowed, unit_ready});
    at(PRD + 2);
    chk("unit_ready", 1'b1, unit_ready);
    for (int i = 0; i < 6; i++)
      ini({8'($urandom % 64), 8'($urandom % 32)});
    ini(16'h10FF);
    @(posedge ref_clk);
    nexus_ok <= 1'b0;
    p_ans <= 16'h3205;
    pulse(10'h200, 3'h0);
    at(6);
    chk("agreed", 16'h190F, agreed);
    @(posedge ref_clk);
    nexus_ok <= 1'b1;
    dev(1'b0, 16'h3204, 16'h3204);
    $display("test negotiation done");
    rises = 0;
    @(posedge ref_clk);
    xfer_want <= 1'b1;
    at(400);
    @(posedge ref_clk);
    xfer_want <= 1'b0;
    at(150);
    chk("req_gap", 1'b1, gmin >= 50);
    chk("req_low", 1'b1, lomin >= NEG_CYC);
    chk("outstanding", 1'b1, pmax <= 4 && rises > 3);
    chk("req_pending", 5'h00, req_pending);
    dev(1'b1, 16'h3204, 16'h0000);
    ini(16'h190F);
    dev(1'b0, 16'h3200, 16'h0000);
    ini(16'h190F);
    pulse(K_BDR, 3'h0);
    at(3);
    chk("agreed", 17'h0, {agreed, sync_mode});
    rises = 0;
    @(posedge ref_clk);
    xfer_want <= 1'b1;
    at(200);
    @(posedge ref_clk);
    xfer_want <= 1'b0;
    at(60);
    chk("async_req", 1'b1, rises > 2 && req_out === 1'b0);
    $display("test transfer done");
    for (int k = 0; k < 4; k++) begin
      fin(3'h2, 5'h10, {1'b0, ST_CHECK});
      at(2);
      chk("ca_owner", 4'hA, {ca_active, ca_owner});
      fin(3'h5, 5'h00, {1'b0, ST_BUSY});
      pulse(K_SNS, 3'h5);
      go(3'h2, 1'b1);
      at(2);
      chk("ca_active", 1'b1, ca_active);
      case (k)
        0: pulse(K_SNS, 3'h2);
        1: go(3'h2, 1'b0);
        2: pulse(K_ABT, 3'h0);
        default: pulse(K_BDR, 3'h0);
      endcase
      at(2);
      chk("ca_active", 1'b0, ca_active);
    end
    for (int k = 0; k < 8; k++) fin(3'($urandom % 8), fl[k], ex[k]);
    // last entry leaves an allegiance for a random owner; drop it
    pulse(K_ABT, 3'h0);
    at(2);
    chk("ca_active", 1'b0, ca_active);
    $display("test status done");
    pulse(K_ARB, 3'h0);
    at(10);
    chk("arb_check_ok", 1'b0, arb_check_ok);
    at(ARB_CYC);
    chk("arb_check_ok", 1'b1, arb_check_ok);
    pulse(K_DSC, 3'h0);
    at(DSC - 5);
    chk("arb_allowed", 1'b0, arb_allowed);
    at(10);
    chk("arb_allowed", 1'b1, arb_allowed);
    pulse(K_SEL, 3'h0);
    at(SLA - 5);
    chk("bsy_resp_ok", 1'b1, bsy_resp_ok);
    at(10);
    chk("bsy_resp_ok", 1'b0, bsy_resp_ok);
    t0 = tos;
    pulse(K_RSL, 3'h0);
    at(STO - 10);
    chk("sel_timeout", 1'b1, tos == t0);
    at(20);
    chk("sel_timeout", 1'b1, tos == t0 + 1);
    pulse(K_RSL, 3'h0);
    pulse(K_BSY, 3'h0);
    at(STO + 20);
    chk("sel_timeout", 1'b1, tos == t0 + 1);
    $display("test timing done");
    ini(16'h1908);
    fin(3'h3, 5'h10, {1'b0, ST_CHECK});
    @(posedge ref_clk);
    bus_rst <= 1'b1;
    @(posedge ref_clk);
    bus_rst <= 1'b0;
    at(2);
    chk("after_rst", 18'h00000, {unit_ready, ca_active, agreed});
    at(RRD + 4);
    chk("unit_ready", 1'b1, unit_ready);
    chk("queues", 16'h0000, 16'(tx_q.size() + st_q.size()));
    $display("test bus reset done");
    summarize();
  end
endmodule
`default_nettype wire
